/* File: design/sub_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SUB_PARAMS_SVH
`define SUB_PARAMS_SVH
`define SUB_OFS_BDH      8'h40
`define SUB_OFS_BDL      8'h41
`define SUB_OFS_C1       8'h42
`define SUB_OFS_C2       8'h43
`define SUB_OFS_S1       8'h44
`define SUB_OFS_S2       8'h45
`define SUB_OFS_C3       8'h46
`define SUB_OFS_DATA     8'h47
`define SUB_RST_BDH      8'h00
`define SUB_RST_BDL      8'h04
`define SUB_BDH_MASK     8'hdf
`define SUB_BDH_BRKIE    7
`define SUB_BDH_RXEIE    6
`define SUB_C1_LOOPS     7
`define SUB_C1_M         4
`define SUB_C1_WAKE      3
`define SUB_C1_ILT       2
`define SUB_C1_PE        1
`define SUB_C1_PT        0
`define SUB_C2_TIE       7
`define SUB_C2_TCIE      6
`define SUB_C2_RIE       5
`define SUB_C2_ILIE      4
`define SUB_C2_TE        3
`define SUB_C2_RE        2
`define SUB_C2_RWU       1
`define SUB_C2_SBK       0
`define SUB_S2_BRKF      7
`define SUB_S2_EDGF      6
`define SUB_S2_BRK13     2
`define SUB_C3_R8        7
`define SUB_C3_T8        6
`define SUB_C3_TXINV     4
`define SUB_C3_ORIE      3
`define SUB_C3_NEIE      2
`define SUB_C3_FEIE      1
`define SUB_C3_PEIE      0
`define SUB_OVS          16
`define SUB_BRK_DET_BITS 11
`define SUB_IDLE_BITS    10
`define SUB_BRK_SHORT    10
`define SUB_BRK_LONG     13
`endif

/* File: design/sub_pkg.sv */
// Types shared by the serial core
package sub_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sub_reg_req_t;

  typedef struct packed {
    logic nine;
    logic par_en;
    logic par_odd;
    logic brk_long;
  } sub_fmt_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } sub_rx_state_t;
endpackage

/* File: design/sub_baud_gen.sv */
// Modulo divider producing the sixteen-per-bit sampling tick
module sub_baud_gen #(
  parameter int unsigned W = 13
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         run,
  input  wire logic [W-1:0] divisor,
  output logic              tick
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (!run || divisor == '0) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q >= divisor - W'(1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick  <= 1'b0;
    end
  end
endmodule

/* File: design/sub_tx.sv */
// Transmit shifter with parity insertion and break frames
`include "sub_params.svh"
module sub_tx
  import sub_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     resetn,
  input  wire logic     tick,
  input  wire logic     enable,
  input  wire logic     buf_full,
  input  wire logic     send_brk,
  input  wire logic [8:0] buf_data,
  input  wire sub_fmt_t fmt,
  output logic          take,
  output logic          idle,
  output logic          line
);
  localparam int unsigned SHW = 15;
  logic [SHW-1:0] sh_q;
  logic [3:0]     bits_q;
  logic [3:0]     sc_q;
  logic           busy_q;
  logic [8:0]     ch;
  logic [3:0]     blen;

  always_comb begin
    ch = buf_data;
    if (!fmt.nine) begin
      ch[8] = 1'b1;
    end
    if (fmt.par_en) begin
      if (fmt.nine) begin
        ch[8] = ^buf_data[7:0] ^ fmt.par_odd;
      end else begin
        ch[7] = ^buf_data[6:0] ^ fmt.par_odd;
      end
    end
    blen = (fmt.brk_long ? 4'(`SUB_BRK_LONG) : 4'(`SUB_BRK_SHORT))
         + {3'b000, fmt.nine};
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sh_q   <= '1;
      bits_q <= 4'h0;
      sc_q   <= 4'h0;
      busy_q <= 1'b0;
      take   <= 1'b0;
    end else begin
      take <= 1'b0;
      if (!busy_q) begin
        sc_q <= 4'h0;
        if (enable && buf_full) begin
          sh_q   <= {{(SHW-10){1'b1}}, ch, 1'b0};
          bits_q <= fmt.nine ? 4'hb : 4'ha;
          busy_q <= 1'b1;
          take   <= 1'b1;
        end else if (enable && send_brk) begin
          sh_q   <= {SHW{1'b1}} << blen;
          bits_q <= blen + 4'h1;
          busy_q <= 1'b1;
        end
      end else if (tick) begin
        sc_q <= sc_q + 4'h1;
        if (sc_q == 4'hf) begin
          sh_q   <= {1'b1, sh_q[SHW-1:1]};
          bits_q <= bits_q - 4'h1;
          busy_q <= (bits_q != 4'h1);
        end
      end
    end
  end

  assign idle = !busy_q;
  assign line = busy_q ? sh_q[0] : 1'b1;
endmodule

/* File: design/sub_core.sv */
// Serial core top: registers, receiver, flags and line pins
// Behaviour
// - Divisor high buffered until low write
// - High bits 4:0, low bits 7:0
// - Zero divisor stops the baud generator
// - Bit rate is clock over sixteen times divisor
// - Generator idle until first enable write
// - Break flag interrupt when its enable set
// - Edge flag interrupt when its enable set
// - Full duplex NRZ, separate transmit and receive
// - Double buffered paths, independent enables
// - Transmit empty and complete flags, irq or poll
// - Receive full and error flags may interrupt
// - Send long break, detect eleven-bit break
// - Eight or nine data bits
// - Hardware parity generate and check
// - Receiver sleep, wake on idle or address
// - Selectable transmit output polarity
// - Start, data LSB first, optional ninth, stop
`include "sub_params.svh"
module sub_core
  import sub_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire sub_reg_req_t reg_req,
  input  wire logic         rxd,
  output logic [7:0]        reg_rdata_q,
  output logic              txd_q,
  output logic              irq_q
);
  localparam int unsigned OVS = `SUB_OVS;
  localparam logic [15:0] RST_DIV = {`SUB_RST_BDH, `SUB_RST_BDL};
  localparam logic [7:0] BRK_THR = 8'(OVS * `SUB_BRK_DET_BITS - 1);

  function automatic logic sel(input sub_reg_req_t r, input logic [7:0] o);
    return r.addr == o;
  endfunction

  logic rxd_s1_q, rxd_s2_q, rx_prev_q;
  logic [7:0] bdh_q, bdl_q, c1_q, c2_q, c3_q;
  logic [12:0] divisor_q;
  logic gen_on_q, rwu_q, brk13_q;
  logic [8:0] tdata_q, rdata_q;
  logic tdre_q, tc_q, rdrf_q, idle_q, or_q, nf_q, fe_q, pf_q;
  logic brkf_q, edgf_q;
  logic wr_bdh, wr_bdl, wr_c2, wr_s2, wr_data, rd_data;
  logic tick, tx_take, tx_idle, tx_line, rx_in;
  sub_fmt_t fmt;

  assign wr_bdh  = reg_req.wr && sel(reg_req, `SUB_OFS_BDH);
  assign wr_bdl  = reg_req.wr && sel(reg_req, `SUB_OFS_BDL);
  assign wr_c2   = reg_req.wr && sel(reg_req, `SUB_OFS_C2);
  assign wr_s2   = reg_req.wr && sel(reg_req, `SUB_OFS_S2);
  assign wr_data = reg_req.wr && sel(reg_req, `SUB_OFS_DATA);
  assign rd_data = reg_req.rd && sel(reg_req, `SUB_OFS_DATA);
  assign fmt = '{nine: c1_q[`SUB_C1_M], par_en: c1_q[`SUB_C1_PE],
                 par_odd: c1_q[`SUB_C1_PT], brk_long: brk13_q};

  // Pin synchroniser
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end else begin
      rxd_s1_q <= rxd;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  assign rx_in = c1_q[`SUB_C1_LOOPS] ? txd_q : rxd_s2_q;

  // Baud divisor
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bdh_q     <= `SUB_RST_BDH;
      bdl_q     <= `SUB_RST_BDL;
      divisor_q <= RST_DIV[12:0];
    end else if (wr_bdh) begin
      bdh_q <= reg_req.wdata & `SUB_BDH_MASK;
    end else if (wr_bdl) begin
      bdl_q     <= reg_req.wdata;
      divisor_q <= {bdh_q[4:0], reg_req.wdata};
    end
  end

  // Control registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      c1_q     <= 8'h00;
      c2_q     <= 8'h00;
      c3_q     <= 8'h00;
      brk13_q  <= 1'b0;
      gen_on_q <= 1'b0;
    end else begin
      if (reg_req.wr && sel(reg_req, `SUB_OFS_C1)) begin
        c1_q <= reg_req.wdata;
      end
      if (reg_req.wr && sel(reg_req, `SUB_OFS_C3)) begin
        c3_q <= reg_req.wdata & 8'h7f;
      end
      if (wr_s2) begin
        brk13_q <= reg_req.wdata[`SUB_S2_BRK13];
      end
      if (wr_c2) begin
        c2_q <= reg_req.wdata;
        if (reg_req.wdata[`SUB_C2_TE] || reg_req.wdata[`SUB_C2_RE]) begin
          gen_on_q <= 1'b1;
        end
      end
    end
  end

  sub_baud_gen #(.W(13)) u_baud (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (gen_on_q),
    .divisor (divisor_q),
    .tick    (tick)
  );

  // Transmit holding buffer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tdata_q <= 9'h000;
      tdre_q  <= 1'b1;
      tc_q    <= 1'b1;
    end else begin
      if (wr_data) begin
        tdata_q <= {c3_q[`SUB_C3_T8], reg_req.wdata};
      end
      tdre_q <= !wr_data && (tx_take || tdre_q);
      tc_q   <= tx_idle && tdre_q && !wr_data;
    end
  end

  sub_tx u_tx (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .tick     (tick),
    .enable   (c2_q[`SUB_C2_TE]),
    .buf_full (!tdre_q),
    .send_brk (c2_q[`SUB_C2_SBK]),
    .buf_data (tdata_q),
    .fmt      (fmt),
    .take     (tx_take),
    .idle     (tx_idle),
    .line     (tx_line)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txd_q <= 1'b1;
    end else begin
      txd_q <= tx_line ^ c3_q[`SUB_C3_TXINV];
    end
  end

  // Receiver
  sub_rx_state_t st_q;
  logic [3:0] sc_q, bc_q;
  logic [1:0] smp_q;
  logic [8:0] rsh_q;
  logic noise_q, maj, mid, rx_done, msb, par_bad, accept, addr_wake;
  logic [8:0] rch;
  logic [7:0] idle_cnt_q, low_cnt_q, idle_thr;
  logic idle_arm_q, idle_hit, brk_hit, edge_hit;

  assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & rx_in)
             | (smp_q[1] & rx_in);
  assign mid = tick && sc_q == 4'h9;
  assign rx_done = mid && st_q == RX_STOP;
  assign rch = c1_q[`SUB_C1_M] ? rsh_q : {1'b0, rsh_q[8:1]};
  assign msb = c1_q[`SUB_C1_M] ? rch[8] : rch[7];
  assign par_bad = c1_q[`SUB_C1_PE]
                 && ((^rch) != c1_q[`SUB_C1_PT]);
  assign addr_wake = rwu_q && c1_q[`SUB_C1_WAKE] && msb;
  assign accept = rx_done && (!rwu_q || addr_wake);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q    <= RX_IDLE;
      sc_q    <= 4'h0;
      bc_q    <= 4'h0;
      smp_q   <= 2'b11;
      rsh_q   <= 9'h000;
      noise_q <= 1'b0;
    end else if (!c2_q[`SUB_C2_RE]) begin
      st_q <= RX_IDLE;
    end else if (tick) begin
      sc_q <= sc_q + 4'h1;
      if (sc_q == 4'h7) begin
        smp_q[0] <= rx_in;
      end
      if (sc_q == 4'h8) begin
        smp_q[1] <= rx_in;
      end
      if (sc_q == 4'h9 && (smp_q[0] != smp_q[1] || smp_q[1] != rx_in)) begin
        noise_q <= 1'b1;
      end
      unique case (st_q)
        RX_IDLE: begin
          sc_q    <= 4'h1;
          noise_q <= 1'b0;
          if (!rx_in) begin
            st_q <= RX_START;
          end else begin
            sc_q <= 4'h0;
          end
        end
        RX_START: begin
          if (sc_q == 4'h9 && maj) begin
            st_q <= RX_IDLE;
          end else if (sc_q == 4'hf) begin
            st_q <= RX_DATA;
            bc_q <= 4'h0;
          end
        end
        RX_DATA: begin
          if (sc_q == 4'h9) begin
            rsh_q <= {maj, rsh_q[8:1]};
          end
          if (sc_q == 4'hf) begin
            bc_q <= bc_q + 4'h1;
            if (bc_q == (c1_q[`SUB_C1_M] ? 4'h8 : 4'h7)) begin
              st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (sc_q == 4'h9) begin
            st_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Idle line and break counters
  assign idle_thr = c1_q[`SUB_C1_M] ? 8'(OVS * (`SUB_IDLE_BITS + 1) - 1)
                                     : 8'(OVS * `SUB_IDLE_BITS - 1);
  assign idle_hit = tick && rx_in && idle_arm_q && idle_cnt_q == idle_thr;
  assign brk_hit = tick && !rx_in && low_cnt_q == BRK_THR;
  assign edge_hit = rx_prev_q && !rx_in && c2_q[`SUB_C2_RE];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_q <= 8'h00;
      low_cnt_q  <= 8'h00;
      idle_arm_q <= 1'b0;
      rx_prev_q  <= 1'b1;
    end else begin
      rx_prev_q <= rx_in;
      if (rx_done) begin
        idle_arm_q <= 1'b1;
      end else if (idle_hit) begin
        idle_arm_q <= 1'b0;
      end
      if (tick) begin
        if (!rx_in || (c1_q[`SUB_C1_ILT] && rx_done)) begin
          idle_cnt_q <= 8'h00;
        end else if (idle_cnt_q != idle_thr + 8'h01) begin
          idle_cnt_q <= idle_cnt_q + 8'h01;
        end
        if (rx_in) begin
          low_cnt_q <= 8'h00;
        end else if (low_cnt_q != BRK_THR + 8'h01) begin
          low_cnt_q <= low_cnt_q + 8'h01;
        end
      end
    end
  end

  // Receive buffer and status flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 9'h000;
      rdrf_q  <= 1'b0;
      or_q    <= 1'b0;
      nf_q    <= 1'b0;
      fe_q    <= 1'b0;
      pf_q    <= 1'b0;
      idle_q  <= 1'b0;
      rwu_q   <= 1'b0;
      brkf_q  <= 1'b0;
      edgf_q  <= 1'b0;
    end else begin
      if (accept && !rdrf_q) begin
        rdata_q <= rch;
      end
      rdrf_q <= (accept && !rdrf_q) || (rdrf_q && !rd_data);
      or_q   <= (accept && rdrf_q) || (or_q && !rd_data);
      nf_q   <= (accept && !rdrf_q && noise_q) || (nf_q && !rd_data);
      fe_q   <= (accept && !rdrf_q && !maj) || (fe_q && !rd_data);
      pf_q   <= (accept && !rdrf_q && par_bad) || (pf_q && !rd_data);
      idle_q <= (idle_hit && !rwu_q) || (idle_q && !rd_data);
      if (wr_c2) begin
        rwu_q <= reg_req.wdata[`SUB_C2_RWU];
      end else if (addr_wake && rx_done
                   || idle_hit && !c1_q[`SUB_C1_WAKE]) begin
        rwu_q <= 1'b0;
      end
      brkf_q <= brk_hit
             || (brkf_q && !(wr_s2 && reg_req.wdata[`SUB_S2_BRKF]));
      edgf_q <= edge_hit
             || (edgf_q && !(wr_s2 && reg_req.wdata[`SUB_S2_EDGF]));
    end
  end

  // Read data and interrupt request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
      irq_q       <= 1'b0;
    end else begin
      irq_q <= (c2_q[`SUB_C2_TIE] && tdre_q)
            || (c2_q[`SUB_C2_TCIE] && tc_q)
            || (c2_q[`SUB_C2_RIE] && rdrf_q)
            || (c2_q[`SUB_C2_ILIE] && idle_q)
            || (c3_q[`SUB_C3_ORIE] && or_q)
            || (c3_q[`SUB_C3_NEIE] && nf_q)
            || (c3_q[`SUB_C3_FEIE] && fe_q)
            || (c3_q[`SUB_C3_PEIE] && pf_q)
            || (bdh_q[`SUB_BDH_BRKIE] && brkf_q)
            || (bdh_q[`SUB_BDH_RXEIE] && edgf_q);
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          `SUB_OFS_BDH:  reg_rdata_q <= bdh_q;
          `SUB_OFS_BDL:  reg_rdata_q <= bdl_q;
          `SUB_OFS_C1:   reg_rdata_q <= c1_q;
          `SUB_OFS_C2:   reg_rdata_q <= {c2_q[7:2], rwu_q, c2_q[0]};
          `SUB_OFS_S1:   reg_rdata_q <= {tdre_q, tc_q, rdrf_q, idle_q,
                                         or_q, nf_q, fe_q, pf_q};
          `SUB_OFS_S2:   reg_rdata_q <= {brkf_q, edgf_q, 3'b000, brk13_q,
                                         2'b00};
          `SUB_OFS_C3:   reg_rdata_q <= {rdata_q[8], c3_q[6:0]};
          `SUB_OFS_DATA: reg_rdata_q <= rdata_q[7:0];
          default:       reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  div_load_a: assert property (wr_bdl |=>
    divisor_q == {$past(bdh_q[4:0]), $past(reg_req.wdata)})
    else $error("divisor not loaded on low write");
  div_hold_a: assert property (wr_bdh |=> $stable(divisor_q))
    else $error("divisor changed on high write");
  gen_stop_a: assert property (
    divisor_q == 13'h0000 && $past(divisor_q) == 13'h0000 |-> !tick)
    else $error("tick with zero divisor");
  gen_reset_a: assert property (!gen_on_q |=> !tick)
    else $error("tick before first enable");
  tick_rate_a: assert property (
    tick && divisor_q == 13'h0002 && !wr_bdl |=> !tick ##1 tick)
    else $error("tick spacing wrong");
  brk_irq_a: assert property (
    brkf_q && bdh_q[`SUB_BDH_BRKIE] |=> irq_q)
    else $error("break interrupt missing");
  edge_irq_a: assert property (
    edgf_q && bdh_q[`SUB_BDH_RXEIE] |=> irq_q)
    else $error("edge interrupt missing");
  tdre_set_a: assert property (
    tx_take |=> tdre_q == !$past(wr_data))
    else $error("empty flag not set on load");
  rdrf_set_a: assert property (accept && !rdrf_q |=> rdrf_q)
    else $error("full flag not set");
  ovr_set_a: assert property (accept && rdrf_q |=> or_q)
    else $error("overrun not flagged");

  rx_frame_c: cover property (accept ##1 rdrf_q);
  brk_seen_c: cover property (brk_hit);
  tx_frame_c: cover property (tx_take ##[1:1000] tc_q);
endmodule

/* File: verification/sub_node.sv */
// Remote serial node: frame sender and transmit line decoder
module sub_node (
  input  wire logic clk_sys,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int         bt = 16;
  int         nb = 8;
  bit         listen = 1;
  logic [9:0] rxq[$];

  initial rxd = 1'b1;

  // Start held lowb bits, data LSB first, stop high
  task automatic send(input logic [8:0] d, input int lowb);
    int i;
    @(negedge clk_sys);
    rxd = 1'b0;
    repeat (bt * lowb) @(negedge clk_sys);
    for (i = 0; i < nb; i++) begin
      rxd = d[i];
      repeat (bt) @(negedge clk_sys);
    end
    rxd = 1'b1;
    repeat (bt * 2) @(negedge clk_sys);
  endtask

  // Mid-bit sampling of each cell, stop level kept in bit 9
  always begin : dec
    logic [9:0] f;
    int         i;
    @(negedge txd);
    if (listen) begin
      f = '0;
      repeat (bt / 2) @(posedge clk_sys);
      for (i = 0; i < nb; i++) begin
        repeat (bt) @(posedge clk_sys);
        f[i] = txd;
      end
      repeat (bt) @(posedge clk_sys);
      f[9] = txd;
      rxq.push_back(f);
    end
  end
endmodule

/* File: verification/sci_uart_baud_core_tb.sv */
// Self-checking bench for the serial core
`include "sub_params.svh"
module sci_uart_baud_core_tb
  import sub_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_sys = 1'b0;
  logic         resetn;
  sub_reg_req_t req;
  logic         rxd;
  logic [7:0]   rdata;
  logic         txd;
  logic         irq;
  int           n_errors;
  int           check_count;
  int           cyc;
  logic [9:0]   expq[$];

  sub_core u_sub_core (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .reg_req     (req),
    .rxd         (rxd),
    .reg_rdata_q (rdata),
    .txd_q       (txd),
    .irq_q       (irq)
  );

  sub_node u_sub_node (
    .clk_sys (clk_sys),
    .txd     (txd),
    .rxd     (rxd)
  );

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    req = '0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    @(negedge clk_sys);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    req = '0;
    chk({2'b00, rdata & m}, {2'b00, e});
  endtask

  // Waits for expected frames, then pairs them with decoded ones
  task automatic drain();
    int k;
    for (k = 0; k < 8000 && u_sub_node.rxq.size() < expq.size(); k++)
      @(posedge clk_sys);
    // Let the last stop bit finish before status reads
    repeat (u_sub_node.bt) @(negedge clk_sys);
    while (expq.size() > 0 && u_sub_node.rxq.size() > 0)
      chk(u_sub_node.rxq.pop_front(), expq.pop_front());
    chk(10'(expq.size() + u_sub_node.rxq.size()), 10'h000);
  endtask

  initial begin
    logic [7:0] d;
    logic [7:0] v;
    int         i;
    req = '0;
    resetn = 1'b0;
    void'($urandom(32'h8e338a91));
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    rchk(`SUB_OFS_BDL, 8'hff, `SUB_RST_BDL);
    rchk(`SUB_OFS_BDH, 8'hff, 8'h00);
    rchk(8'h50, 8'hff, 8'h00);
    chk({9'b0, txd}, 10'h001);
    $display("test reset done");
    wr(`SUB_OFS_BDH, 8'h00);
    wr(`SUB_OFS_BDL, 8'h02);
    wr(`SUB_OFS_C2, 8'h0c);
    wr(`SUB_OFS_BDH, 8'h01);
    u_sub_node.bt = 32;
    for (i = 0; i < 2; i++) begin
      d = 8'($urandom);
      wr(`SUB_OFS_DATA, d);
      expq.push_back({2'b10, d});
    end
    drain();
    rchk(`SUB_OFS_S1, 8'hc0, 8'hc0);
    wr(`SUB_OFS_BDH, 8'h00);
    wr(`SUB_OFS_BDL, 8'h01);
    u_sub_node.bt = 16;
    wr(`SUB_OFS_C1, 8'h10);
    wr(`SUB_OFS_C3, 8'h40);
    u_sub_node.nb = 9;
    d = 8'($urandom);
    wr(`SUB_OFS_DATA, d);
    expq.push_back({2'b11, d});
    drain();
    wr(`SUB_OFS_C3, 8'h00);
    u_sub_node.nb = 8;
    for (i = 0; i < 2; i++) begin
      wr(`SUB_OFS_C1, 8'h02 | 8'(i));
      d = 8'($urandom);
      wr(`SUB_OFS_DATA, d);
      v = {(^d[6:0]) ^ i[0], d[6:0]};
      expq.push_back({2'b10, v});
      drain();
    end
    wr(`SUB_OFS_C1, 8'h00);
    $display("test transmit done");
    for (i = 0; i < 2; i++) begin
      d = 8'($urandom);
      if (i == 0)
        v = d;
      u_sub_node.send({1'b0, d}, 1);
    end
    repeat (200) @(negedge clk_sys);
    rchk(`SUB_OFS_S1, 8'h38, 8'h38);
    rchk(`SUB_OFS_DATA, 8'hff, v);
    rchk(`SUB_OFS_S1, 8'h38, 8'h00);
    wr(`SUB_OFS_C1, 8'h12);
    u_sub_node.nb = 9;
    d = 8'($urandom);
    u_sub_node.send({~^d, d}, 1);
    rchk(`SUB_OFS_S1, 8'h21, 8'h21);
    rchk(`SUB_OFS_C3, 8'h80, {~^d, 7'b0});
    rchk(`SUB_OFS_DATA, 8'hff, d);
    u_sub_node.nb = 8;
    $display("test receive done");
    wr(`SUB_OFS_C1, 8'h08);
    wr(`SUB_OFS_C2, 8'h0e);
    u_sub_node.send(9'h012, 1);
    rchk(`SUB_OFS_S1, 8'h20, 8'h00);
    u_sub_node.send(9'h095, 1);
    rchk(`SUB_OFS_S1, 8'h20, 8'h20);
    rchk(`SUB_OFS_C2, 8'h02, 8'h00);
    rchk(`SUB_OFS_DATA, 8'hff, 8'h95);
    wr(`SUB_OFS_C1, 8'h00);
    wr(`SUB_OFS_C2, 8'h0e);
    u_sub_node.send(9'h033, 1);
    repeat (200) @(negedge clk_sys);
    rchk(`SUB_OFS_C2, 8'h02, 8'h00);
    rchk(`SUB_OFS_S1, 8'h20, 8'h00);
    $display("test wake done");
    wr(`SUB_OFS_BDH, 8'hc0);
    wr(`SUB_OFS_BDL, 8'h01);
    wr(`SUB_OFS_S2, 8'hc0);
    rchk(`SUB_OFS_S2, 8'hc0, 8'h00);
    chk({9'b0, irq}, 10'h000);
    u_sub_node.send(9'h05a, 1);
    rchk(`SUB_OFS_S2, 8'hc0, 8'h40);
    chk({9'b0, irq}, 10'h001);
    wr(`SUB_OFS_S2, 8'h40);
    rchk(`SUB_OFS_DATA, 8'hff, 8'h5a);
    chk({9'b0, irq}, 10'h000);
    u_sub_node.send(9'h000, 12);
    rchk(`SUB_OFS_S2, 8'h80, 8'h80);
    chk({9'b0, irq}, 10'h001);
    rchk(`SUB_OFS_S1, 8'h0a, 8'h0a);
    wr(`SUB_OFS_S2, 8'hc0);
    rchk(`SUB_OFS_DATA, 8'h00, 8'h00);
    chk({9'b0, irq}, 10'h000);
    $display("test flags done");
    for (i = 0; i < 2; i++) begin
      wr(`SUB_OFS_S2, 8'(i << 2));
      wr(`SUB_OFS_C2, 8'h0d);
      wr(`SUB_OFS_C2, 8'h0c);
      expq.push_back(10'h000);
      drain();
      repeat (300) @(negedge clk_sys);
      u_sub_node.rxq.delete();
    end
    u_sub_node.listen = 0;
    wr(`SUB_OFS_C3, 8'h10);
    repeat (2) @(negedge clk_sys);
    chk({9'b0, txd}, 10'h000);
    wr(`SUB_OFS_C3, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk({9'b0, txd}, 10'h001);
    wr(`SUB_OFS_BDH, 8'h00);
    wr(`SUB_OFS_BDL, 8'h00);
    wr(`SUB_OFS_DATA, 8'h55);
    repeat (400) @(negedge clk_sys);
    rchk(`SUB_OFS_S1, 8'h40, 8'h00);
    $display("test line done");
    close_out();
  end
endmodule
